// *** inc/pvs_regs.svh ***
// register offsets, field positions and reset values of the print video serializer
// assumes a 12-bit APB byte address with one 32-bit word per register
`ifndef PVS_REGS_SVH
`define PVS_REGS_SVH

// byte offsets
`define PVS_CTRL_OFF      12'h000
`define PVS_LINE_LEN_OFF  12'h004
`define PVS_PAGE_LEN_OFF  12'h008
`define PVS_DATA_OFF      12'h00C
`define PVS_STATUS_OFF    12'h010

// control fields
`define PVS_CTRL_START     0
`define PVS_CTRL_PAGE_POL  1
`define PVS_CTRL_LINE_POL  2
`define PVS_CTRL_PRINT_POL 3
`define PVS_CTRL_VIDEO_POL 4

// status fields
`define PVS_STAT_BUSY      0
`define PVS_STAT_PAGE_DONE 1
`define PVS_STAT_UNDERRUN  2
`define PVS_STAT_EMPTY     3
`define PVS_STAT_FULL      4
`define PVS_STAT_LINE      5

// reset values
`define PVS_POL_RESET      4'h7
`define PVS_LINE_LEN_RESET 16'h0400
`define PVS_PAGE_LEN_RESET 16'h0100

`endif

// *** inc/pvs_pkg.sv ***
// types shared by the print video serializer files
// assumes nothing beyond a SystemVerilog compiler
package pvs_pkg;

  // apb request from the master
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } pvs_apb_req_t;

  // active levels: 1 means active high
  typedef struct packed {
    logic video;
    logic print;
    logic line;
    logic page;
  } pvs_pol_t;

  // page sequencer states
  typedef enum logic [1:0] {
    PVS_IDLE,
    PVS_WAIT_PAGE,
    PVS_WAIT_LINE,
    PVS_SHIFT
  } pvs_state_t;

endpackage

// *** hw/pvs_fifo.sv ***
// synchronous fifo carrying video words from the register bus to the shifter
// assumes one clock, synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none

module pvs_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input  wire logic             mclk_in,
  input  wire logic             reset_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  logic             push;
  logic             pop;

  // handshakes
  assign in_ready_out  = (count_r != (AW+1)'(DEPTH));
  assign out_valid_out = (count_r != '0);
  assign push          = in_valid_in & in_ready_out;
  assign pop           = out_ready_in & out_valid_out;
  assign out_data_out  = mem_r[rd_ptr_r];

  // storage
  always_ff @(posedge mclk_in)
  begin
    if (push) mem_r[wr_ptr_r] <= in_data_in;
  end

  // pointers and fill level
  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end
    else
    begin
      if (push) wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
      if (pop)  rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
      if (push & ~pop)      count_r <= count_r + 1'b1;
      else if (pop & ~push) count_r <= count_r - 1'b1;
    end
  end
endmodule // pvs_fifo

`default_nettype wire

// *** hw/pvs_top.sv ***
// print video serializer: apb registers, page/line sequencer, serial video out
// assumes the video shift clock and both syncs are asynchronous to mclk_in,
// and that the video clock is well below half the mclk_in rate
//
// What this block does
// - page starts only after frame sync seen at its programmed active level.
// - one scanline sent per recognized line sync assertion, programmable polarity.
// - print request output asserted at programmable polarity when ready to print.
// - serial video on one pin, default low active, polarity programmable.
`timescale 1ns/1ps
`default_nettype none
`include "pvs_regs.svh"

module pvs_top #(
  parameter int FIFO_DEPTH = 16,
  parameter int LEN_W      = 16
) (
  input  wire logic                  mclk_in,
  input  wire logic                  reset_in,
  input  wire pvs_pkg::pvs_apb_req_t apb_in,
  output logic [31:0]                prdata_out,
  output logic                       pready_out,
  output logic                       pslverr_out,
  input  wire logic                  video_shift_clock_in,
  input  wire logic                  page_sync_in,
  input  wire logic                  scanline_sync_in,
  output logic                       print_request_out,
  output logic                       video_data_out
);
  import pvs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [2:0] video_shift_clock_sync_r;
  logic [2:0] page_sync_r;
  logic [2:0] line_sync_r;
  logic       video_shift_clock_lvl_r;
  logic       page_lvl_r;
  logic       line_lvl_r;
  logic       line_act_prev_r;

  // three flops per pin, first flop feeds only the second
  always_ff @(posedge mclk_in)
  begin
    video_shift_clock_sync_r <= {video_shift_clock_sync_r[1:0], video_shift_clock_in};
    page_sync_r <= {page_sync_r[1:0], page_sync_in};
    line_sync_r <= {line_sync_r[1:0], scanline_sync_in};
  end

  // a level counts once the second and third flops agree
  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      video_shift_clock_lvl_r <= 1'b0;
      page_lvl_r <= 1'b0;
      line_lvl_r <= 1'b0;
    end
    else
    begin
      if (video_shift_clock_sync_r[1] == video_shift_clock_sync_r[2]) video_shift_clock_lvl_r <= video_shift_clock_sync_r[2];
      if (page_sync_r[1] == page_sync_r[2]) page_lvl_r <= page_sync_r[2];
      if (line_sync_r[1] == line_sync_r[2]) line_lvl_r <= line_sync_r[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  pvs_pol_t         pol_r;
  logic [LEN_W-1:0] line_len_r;
  logic [LEN_W-1:0] page_len_r;
  logic             page_done_r;
  logic             underrun_r;
  logic [31:0]      rdata_r;
  pvs_state_t       state_r;
  pvs_state_t       state_nxt;

  wire apb_setup  = apb_in.psel & ~apb_in.penable;
  wire apb_access = apb_in.psel & apb_in.penable;
  wire sel_ctrl   = (apb_in.paddr == `PVS_CTRL_OFF);
  wire sel_llen   = (apb_in.paddr == `PVS_LINE_LEN_OFF);
  wire sel_plen   = (apb_in.paddr == `PVS_PAGE_LEN_OFF);
  wire sel_data   = (apb_in.paddr == `PVS_DATA_OFF);
  wire sel_stat   = (apb_in.paddr == `PVS_STATUS_OFF);
  wire mapped     = sel_ctrl | sel_llen | sel_plen | sel_data | sel_stat;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [31:0] fifo_out_data;

  // data writes stall while the fifo is full
  assign pready_out  = ~(apb_in.pwrite & sel_data & ~fifo_in_ready);
  assign pslverr_out = apb_access & ~mapped;
  assign prdata_out  = rdata_r;

  wire wr_fire  = apb_access & apb_in.pwrite & pready_out;
  wire wr_ctrl  = wr_fire & sel_ctrl;
  wire wr_stat  = wr_fire & sel_stat;
  wire fifo_push_valid = apb_access & apb_in.pwrite & sel_data;
  wire start_req = wr_ctrl & apb_in.pwdata[`PVS_CTRL_START];

  // read mux, sampled in the setup phase
  wire [31:0] ctrl_rd = {27'h000_0000, pol_r.video, pol_r.print, pol_r.line, pol_r.page,
                         1'b0};
  wire [31:0] stat_rd = {26'h000_0000, (state_r == PVS_SHIFT), ~fifo_in_ready,
                         ~fifo_out_valid, underrun_r, page_done_r, (state_r != PVS_IDLE)};
  wire [31:0] rd_mux  = sel_ctrl ? ctrl_rd :
                        sel_llen ? 32'(line_len_r) :
                        sel_plen ? 32'(page_len_r) :
                        sel_stat ? stat_rd : 32'h0000_0000;

  // software-written configuration
  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      pol_r      <= `PVS_POL_RESET;
      line_len_r <= `PVS_LINE_LEN_RESET;
      page_len_r <= `PVS_PAGE_LEN_RESET;
      rdata_r    <= 32'h0000_0000;
    end
    else
    begin
      if (wr_ctrl) pol_r <= apb_in.pwdata[`PVS_CTRL_VIDEO_POL:`PVS_CTRL_PAGE_POL];
      if (wr_fire & sel_llen) line_len_r <= apb_in.pwdata[LEN_W-1:0];
      if (wr_fire & sel_plen) page_len_r <= apb_in.pwdata[LEN_W-1:0];
      if (apb_setup) rdata_r <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // page and line sequencer

  logic [LEN_W-1:0] bits_sent_r;
  logic [LEN_W-1:0] lines_sent_r;
  logic [5:0]       word_left_r;
  logic [31:0]      shift_r;
  logic             bit_r;

  wire video_shift_clock_rise = (video_shift_clock_sync_r[1] == video_shift_clock_sync_r[2]) & video_shift_clock_sync_r[2] & ~video_shift_clock_lvl_r;
  wire page_act  = (page_lvl_r == pol_r.page);
  wire line_act  = (line_lvl_r == pol_r.line);
  wire line_rise = line_act & ~line_act_prev_r;
  wire shifting  = (state_r == PVS_SHIFT) & video_shift_clock_rise;
  wire line_end  = shifting & (bits_sent_r == line_len_r);
  wire page_end  = line_end & (lines_sent_r + 1'b1 == page_len_r);
  wire need_word = shifting & ~line_end & (word_left_r == 6'h00);
  wire underrun  = need_word & ~fifo_out_valid;
  wire fifo_pop  = need_word;

  // state transitions
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      PVS_IDLE:      if (start_req) state_nxt = PVS_WAIT_PAGE;
      PVS_WAIT_PAGE: if (page_act) state_nxt = PVS_WAIT_LINE;
      PVS_WAIT_LINE: if (line_rise) state_nxt = PVS_SHIFT;
      PVS_SHIFT:     if (line_end) state_nxt = page_end ? PVS_IDLE : PVS_WAIT_LINE;
    endcase
  end

  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      state_r         <= PVS_IDLE;
      line_act_prev_r <= 1'b1;
    end
    else
    begin
      state_r         <= state_nxt;
      line_act_prev_r <= line_act;
    end
  end

  // line and page counters
  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      bits_sent_r  <= '0;
      lines_sent_r <= '0;
    end
    else
    begin
      if (state_r == PVS_WAIT_PAGE) lines_sent_r <= '0;
      else if (line_end) lines_sent_r <= lines_sent_r + 1'b1;
      if (state_r == PVS_WAIT_LINE) bits_sent_r <= '0;
      else if (shifting & ~line_end) bits_sent_r <= bits_sent_r + 1'b1;
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      shift_r     <= 32'h0000_0000;
      word_left_r <= 6'h00;
      bit_r       <= 1'b0;
    end
    else if (state_r != PVS_SHIFT)
    begin
      word_left_r <= 6'h00;
      bit_r       <= 1'b0;
    end
    else if (line_end)
      bit_r <= 1'b0;
    else if (need_word)
    begin
      shift_r     <= {fifo_out_data[30:0], 1'b0};
      word_left_r <= fifo_out_valid ? 6'd31 : 6'h00;
      bit_r       <= fifo_out_valid & fifo_out_data[31];
    end
    else if (shifting)
    begin
      shift_r     <= {shift_r[30:0], 1'b0};
      word_left_r <= word_left_r - 1'b1;
      bit_r       <= shift_r[31];
    end
  end

  // sticky flags, set wins over write-one-to-clear
  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      page_done_r <= 1'b0;
      underrun_r  <= 1'b0;
    end
    else
    begin
      page_done_r <= page_end | (page_done_r & ~(wr_stat & apb_in.pwdata[`PVS_STAT_PAGE_DONE]));
      underrun_r  <= underrun | (underrun_r & ~(wr_stat & apb_in.pwdata[`PVS_STAT_UNDERRUN]));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output pins

  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      print_request_out <= 1'b0;
      video_data_out    <= 1'b1;
    end
    else
    begin
      print_request_out <= ~((state_r != PVS_IDLE) ^ pol_r.print);
      video_data_out    <= ~(bit_r ^ pol_r.video);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // video word buffer

  pvs_fifo #(
    .WIDTH (32),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk_in       (mclk_in),
    .reset_in      (reset_in),
    .in_valid_in   (fifo_push_valid),
    .in_ready_out  (fifo_in_ready),
    .in_data_in    (apb_in.pwdata),
    .out_valid_out (fifo_out_valid),
    .out_ready_in  (fifo_pop),
    .out_data_out  (fifo_out_data)
  );
endmodule // pvs_top

`default_nettype wire

// *** sim/pvs_top_properties.sv ***
// port checker for the print video serializer
// assumes one mclk_in domain, bound to pvs_top below
`timescale 1ns/1ps
`default_nettype none
module pvs_top_properties (
  input wire logic                  mclk_in,
  input wire logic                  reset_in,
  input wire pvs_pkg::pvs_apb_req_t apb_in,
  input wire logic                  pready_out,
  input wire logic                  pslverr_out,
  input wire logic                  video_shift_clock_in,
  input wire logic                  page_sync_in,
  input wire logic                  scanline_sync_in,
  input wire logic                  print_request_out,
  input wire logic                  video_data_out
);
  import pvs_pkg::*;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (reset_in);
  logic [4:0] ctl_r;
  logic [3:0] vc_r;
  logic       pg_r;
  logic       ln_r;
  // bus decode and active levels
  wire acc    = apb_in.psel && apb_in.penable;
  wire wr_ctl = acc && pready_out && apb_in.pwrite && apb_in.paddr == 12'h000;
  wire idle   = print_request_out != ctl_r[3];
  wire v_off  = video_data_out != ctl_r[4];
  // control mirror, cycles since clock rise, sync history
  always_ff @(posedge mclk_in)
  begin
    ctl_r <= reset_in ? 5'h0E : wr_ctl ? apb_in.pwdata[4:0] : ctl_r;
    vc_r  <= (reset_in || vc_r == 4'hF) ? 4'hF : vc_r + 4'h1;
    if ($rose(video_shift_clock_in))
      vc_r <= 4'h0;
    pg_r  <= !reset_in && !idle && (pg_r || page_sync_in == ctl_r[1]);
    ln_r  <= !reset_in && !idle && (ln_r || pg_r && scanline_sync_in == ctl_r[2]);
  end
  a_reset_idle:
    assert property (disable iff (1'b0) reset_in |=> !print_request_out && video_data_out)
    else $error("outputs active after reset");
  a_start_request:
    assert property (wr_ctl && apb_in.pwdata[0] && idle |-> ##[1:4] !idle)
    else $error("no print request after start");
  a_video_paced:
    assert property ($changed(video_data_out) && ctl_r == $past(ctl_r, 2) |->
                     vc_r >= 4'h3 && vc_r <= 4'h5)
    else $error("video moved without a clock rise");
  a_page_first:
    assert property (!pg_r && ctl_r == $past(ctl_r, 2) |-> v_off)
    else $error("video before page sync");
  a_line_first:
    assert property (!ln_r && ctl_r == $past(ctl_r, 2) |-> v_off)
    else $error("video before line sync");
  a_idle_video:
    assert property (idle && $past(idle) && ctl_r == $past(ctl_r, 2) |-> v_off)
    else $error("video active while idle");
  a_bus_err:
    assert property (acc |-> pslverr_out == (apb_in.paddr > 12'h010 ||
                                             apb_in.paddr[1:0] != 2'b00))
    else $error("slave error wrong");
  a_bus_ready:
    assert property (acc && apb_in.paddr != 12'h00C |-> pready_out)
    else $error("register access stalled");
  c_start: cover property (wr_ctl && apb_in.pwdata[0]);
  c_page: cover property (pg_r);
  c_line: cover property (ln_r && !v_off);
endmodule // pvs_top_properties
bind pvs_top pvs_top_properties u_props (.mclk_in, .reset_in, .apb_in, .pready_out,
  .pslverr_out, .video_shift_clock_in, .page_sync_in, .scanline_sync_in,
  .print_request_out, .video_data_out);
`default_nettype wire

// *** sim/pvs_engine_model.sv ***
// laser engine stand-in: video clock, syncs, bit capture
// assumes request and video at the levels given in pol_in
`timescale 1ns/1ps
`default_nettype none
module pvs_engine_model (
  input  wire logic              prq_in,
  input  wire logic              video_in,
  input  wire pvs_pkg::pvs_pol_t pol_in,
  output logic                   video_shift_clock_out,
  output logic                   page_out,
  output logic                   line_out,
  output int                     lines_out,
  output logic [47:0]            bits_out
);
  import pvs_pkg::*;
  logic pg_r;
  logic ln_r;
  assign page_out = pg_r ~^ pol_in.page;
  assign line_out = ln_r ~^ pol_in.line;
  // free-running 80 ns video clock, one driving process
  initial
  begin
    video_shift_clock_out = 1'b0;
    forever #40 video_shift_clock_out = ~video_shift_clock_out;
  end
  // one page per request, a fresh line sync for each line
  initial
  begin
    pg_r = 1'b0;
    ln_r = 1'b0;
    lines_out = 0;
    bits_out = '0;
    forever
    begin
      // a page starts on a change of the request into its active level,
      // so a polarity rewrite while idle is not taken as a request
      do
        @(prq_in);
      while (prq_in !== pol_in.print);
      @(negedge video_shift_clock_out) pg_r = 1'b1;
      while (prq_in === pol_in.print)
      begin
        repeat (4) @(negedge video_shift_clock_out);
        ln_r = 1'b1;
        repeat (44) @(posedge video_shift_clock_out) bits_out = {bits_out[46:0], video_in === pol_in.video};
        ln_r = 1'b0;
        lines_out++;
      end
      pg_r = 1'b0;
    end
  end
endmodule // pvs_engine_model
`default_nettype wire

// *** sim/tb_top.sv ***
// self-checking bench for the print video serializer
// assumes pvs_top, the engine model and the bound checker
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import pvs_pkg::*;
  typedef struct {logic [11:0] a; logic w; logic [31:0] d; logic [31:0] q; logic e;} pvs_row_t;
  localparam logic [31:0] WORD = 32'hA5C3_0F96;
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  pvs_apb_req_t apb = '0;
  pvs_pol_t     pol = 4'h7;
  logic [31:0]  prdata, q;
  logic         pready, pslverr, video_shift_clock, pgs, lns, prq, vid, e;
  logic [47:0]  bits;
  int           lines, errors = 0, checks_done = 0;
  pvs_row_t     rows [11] = '{
    '{12'h000, 1'b0, 32'h0, 32'h0000_000E, 1'b0}, '{12'h004, 1'b0, 32'h0, 32'h0000_0400, 1'b0},
    '{12'h008, 1'b0, 32'h0, 32'h0000_0100, 1'b0}, '{12'h010, 1'b0, 32'h0, 32'h0000_0008, 1'b0},
    '{12'h00C, 1'b0, 32'h0, 32'h0, 1'b0}, '{12'h014, 1'b0, 32'h0, 32'h0, 1'b1},
    '{12'h014, 1'b1, 32'h0, 32'h0, 1'b1}, '{12'h004, 1'b1, 32'h0000_0020, 32'h0, 1'b0},
    '{12'h004, 1'b0, 32'h0, 32'h0000_0020, 1'b0}, '{12'h008, 1'b1, 32'h0000_0002, 32'h0, 1'b0},
    '{12'h008, 1'b0, 32'h0, 32'h0000_0002, 1'b0}};
  always #5 clk = ~clk;
  pvs_top dut (.mclk_in(clk), .reset_in(rst), .apb_in(apb), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .video_shift_clock_in(video_shift_clock),
    .page_sync_in(pgs), .scanline_sync_in(lns), .print_request_out(prq), .video_data_out(vid));
  pvs_engine_model eng (.prq_in(prq), .video_in(vid), .pol_in(pol), .video_shift_clock_out(video_shift_clock),
    .page_out(pgs), .line_out(lns), .lines_out(lines), .bits_out(bits));
  ////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cmp(string n, logic [31:0] x, logic [31:0] s);
    checks_done++;
    if (s !== x)
    begin
      errors++;
      $display("unexpected %s: expected %h seen %h", n, x, s);
    end
  endtask
  // one apb transfer, waits for pready under a bound
  task automatic xfer(logic [11:0] a, logic w, logic [31:0] d);
    int n;
    apb <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    apb.penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 3000);
    q = prdata;
    e = pslverr;
    apb <= '0;
    if (n >= 3000)
    begin
      errors++;
      finish_test();
    end
    @(posedge clk);
  endtask
  task automatic wait_lines(int t);
    for (int n = 0; n < 30000 && lines < t; n++)
      @(posedge clk);
    if (lines < t)
    begin
      errors++;
      finish_test();
    end
  endtask
  // five idle samples, 32 bits msb first, then idle up to the window end
  function automatic logic [31:0] found(logic [47:0] b, logic [31:0] w);
    found = {31'h0000_0000, b === {5'h00, w, 11'h000}};
  endfunction
  // main sequence
  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    cmp("idle request video", 32'h1, {30'h0, prq, vid});
    foreach (rows[k])
    begin
      xfer(rows[k].a, rows[k].w, rows[k].d);
      if (!rows[k].w)
        cmp("read data", rows[k].q, q);
      cmp("slave error", {31'h0, rows[k].e}, {31'h0, e});
    end
    $display("registers done");
    for (int k = 0; k < 16; k++)
      xfer(12'h00C, 1'b1, WORD);
    xfer(12'h010, 1'b0, 32'h0);
    cmp("status full", 32'h0000_0010, q);
    xfer(12'h000, 1'b1, 32'h0000_000F);
    xfer(12'h00C, 1'b1, WORD);
    wait_lines(2);
    cmp("line bits", 32'h1, found(bits, WORD));
    xfer(12'h010, 1'b0, 32'h0);
    cmp("status page done", 32'h0000_0002, q);
    xfer(12'h010, 1'b1, 32'h0000_0002);
    xfer(12'h010, 1'b0, 32'h0);
    cmp("status cleared", 32'h0, q);
    $display("default page done");
    xfer(12'h008, 1'b1, 32'h0000_000F);
    // engine levels change first, so the idle request flip starts no page
    pol <= 4'h8;
    xfer(12'h000, 1'b1, 32'h0000_0010);
    repeat (8) @(posedge clk);
    xfer(12'h000, 1'b1, 32'h0000_0011);
    wait_lines(17);
    cmp("inverted bits", 32'h1, found(bits, WORD));
    xfer(12'h010, 1'b0, 32'h0);
    cmp("status drained", 32'h0000_000A, q);
    $display("inverted page done");
    xfer(12'h008, 1'b1, 32'h0000_0001);
    xfer(12'h000, 1'b1, 32'h0000_0011);
    for (int k = 0; k < 200 && q[2] !== 1'b1; k++)
      xfer(12'h010, 1'b0, 32'h0);
    cmp("underrun status", 32'h0000_002F, q);
    rst <= 1'b1;
    pol <= 4'h7;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    cmp("reset request video", 32'h1, {30'h0, prq, vid});
    xfer(12'h000, 1'b0, 32'h0);
    cmp("control after reset", 32'h0000_000E, q);
    $display("underrun and reset done");
    finish_test();
  end
endmodule // tb_top
`default_nettype wire
